//--- pkg/aeqf_iir_if.sv
// Connection between the chain and one first-order filter section.
`timescale 1ns/1ps
interface aeqf_iir_if;
  import aeqf_pkg::*;
  logic stb;
  logic clr;
  aeqf_coef_t b0;
  aeqf_coef_t b1;
  aeqf_coef_t a1;
  aeqf_sample_t x;
  aeqf_sample_t y;
  modport filt (input stb, input clr, input b0, input b1, input a1, input x, output y);
  modport ctrl (output stb, output clr, output b0, output b1, output a1, output x, input y);
endinterface

//--- pkg/aeqf_pkg.sv
// Shared constants and the saturation helper for the audio filter chain.
package aeqf_pkg;
  localparam int SAMPLE_W = 16;
  localparam int COEF_W = 16;
  localparam int WIND_COEF_W = 14;
  localparam int EQ_B_W = 14;
  localparam int COEF_FRAC = 13;
  localparam int SAT_IN_W = 48;
  // Leaky integrator shift; the cut-off is about fs * 2^-13 / (2 * pi), which is
  // 0.86 Hz at 44.1 kHz and moves with the sample rate by construction.
  localparam real DC_FC_HZ = 0.9;
  localparam real DC_FS_HZ = 44100.0;
  localparam int DC_SHIFT = 13;
  localparam int DC_FRAC = 8;
  localparam int DC_ACC_W = SAMPLE_W + DC_FRAC + 2;
  localparam logic [1:0] GAIN_0DB = 2'h0;
  localparam logic [1:0] GAIN_12DB = 2'h1;
  localparam int GAIN_12DB_SHIFT = 2;
  localparam int GAIN_24DB_SHIFT = 4;
  localparam logic TYPE_HPF = 1'b0;
  localparam logic TYPE_LPF = 1'b1;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MAX = 16'sh7FFF;
  localparam logic signed [SAMPLE_W-1:0] SAMPLE_MIN = -16'sh8000;

  typedef logic signed [SAMPLE_W-1:0] aeqf_sample_t;
  typedef logic signed [COEF_W-1:0] aeqf_coef_t;

  // Clips a wide signed value into the sample range.
  function automatic aeqf_sample_t aeqf_sat(input logic signed [SAT_IN_W-1:0] v);
    aeqf_sample_t r;
    r = v[SAMPLE_W-1:0];
    if (v > SAT_IN_W'(SAMPLE_MAX))
      r = SAMPLE_MAX;
    else if (v < SAT_IN_W'(SAMPLE_MIN))
      r = SAMPLE_MIN;
    return r;
  endfunction
endpackage

//--- src/aeqf_chain.sv
// Audio DC high-pass filter and programmable wind, separation and EQ chain.
// How it works
// R01 - A leaky DC blocker near 0.9 Hz at 44.1 kHz, scaling with fs.
// R02 - Any ADC powered: DC filter on the ADC path, DAC path bypassed.
// R03 - Only DAC powered: DC filter on the DAC path, ADC path bypassed.
// R04 - Chain on recording when any ADC is on, playback if only DAC.
// R05 - Coefficients and enables are plain inputs, untouched by path changes.
// R06 - Software clears chain enables and gain when playback needs no filtering.
// R07 - Wind, separation and EQ are first-order IIR sections, any coefficients.
// R08 - Type select 0 makes wind or separation a high-pass, 1 a low-pass.
// R09 - Disabled wind or EQ stage passes samples unchanged.
// R10 - Disabled separation stage contributes silence.
// R11 - Software disables a stage before changing its coefficients.
// R12 - Separation coefficients set how strongly the channel difference is emphasised.
// R13 - Separation emphasis acts only in stereo operation.
// R14 - Gain select 00 gives 0 dB, 01 gives +12 dB, 1x gives +24 dB.
// R15 - Mono mix while recording leaves only the wind stage active.
// R16 - Samples pass wind, separation, EQ and gain all digitally.
// R17 - Coefficients are two's complement, scaled by 2^13.
// R18 - Wind and separation A, B and EQ B are 14 bits; EQ A, C 16.
// R19 - Sections compute HPF, LPF and EQ transfer functions once per sample.
// R20 - Filter state clears whenever the chain is powered down.
`timescale 1ns/1ps
module aeqf_chain
  import aeqf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sample_stb,
  input wire logic signed [SAMPLE_W-1:0] i_adc_l,
  input wire logic signed [SAMPLE_W-1:0] i_adc_r,
  input wire logic signed [SAMPLE_W-1:0] i_dac_l,
  input wire logic signed [SAMPLE_W-1:0] i_dac_r,
  input wire logic i_left_adc_power_en,
  input wire logic i_right_adc_power_en,
  input wire logic i_dac_power_en,
  input wire logic i_mono_mix,
  input wire logic i_wind_filter_en,
  input wire logic i_wind_filter_type_sel,
  input wire logic signed [WIND_COEF_W-1:0] i_wind_coef_a,
  input wire logic signed [WIND_COEF_W-1:0] i_wind_coef_b,
  input wire logic i_separation_filter_en,
  input wire logic i_separation_filter_type_sel,
  input wire logic signed [WIND_COEF_W-1:0] i_separation_coef_a,
  input wire logic signed [WIND_COEF_W-1:0] i_separation_coef_b,
  input wire logic i_eq_en,
  input wire logic signed [COEF_W-1:0] i_eq_coef_a,
  input wire logic signed [EQ_B_W-1:0] i_eq_coef_b,
  input wire logic signed [COEF_W-1:0] i_eq_coef_c,
  input wire logic [1:0] i_comp_gain_sel,
  output logic signed [SAMPLE_W-1:0] o_adc_l,
  output logic signed [SAMPLE_W-1:0] o_adc_r,
  output logic signed [SAMPLE_W-1:0] o_dac_l,
  output logic signed [SAMPLE_W-1:0] o_dac_r,
  output logic o_valid,
  output logic o_chain_on_rec,
  output logic o_chain_on_play
);
  aeqf_sample_t adc_in [2];
  aeqf_sample_t dac_in [2];
  aeqf_sample_t src [2];
  aeqf_sample_t dc_out [2];
  aeqf_sample_t wind_out [2];
  aeqf_sample_t sep_y [2];
  aeqf_sample_t sep_out [2];
  aeqf_sample_t eq_out [2];
  aeqf_sample_t gain_out [2];
  logic signed [SAT_IN_W-1:0] gain_full [2];
  logic signed [DC_ACC_W-1:0] dc_y_r [2];
  aeqf_sample_t dc_x1_r [2];
  aeqf_sample_t adc_r [2];
  aeqf_sample_t dac_r [2];
  logic valid_r;
  logic rec_r;
  logic play_r;

  wire any_adc = i_left_adc_power_en | i_right_adc_power_en;
  wire on_rec = any_adc; // R04
  wire on_play = !any_adc & i_dac_power_en; // R04
  wire chain_off = !on_rec & !on_play;
  wire stereo = on_play | (i_left_adc_power_en & i_right_adc_power_en & !i_mono_mix);
  wire wind_on = i_wind_filter_en & !chain_off;
  wire sep_on = i_separation_filter_en & stereo & !chain_off; // R13 R15
  wire eq_on = i_eq_en & !(on_rec & i_mono_mix) & !chain_off; // R15
  wire [2:0] gain_shift = (i_comp_gain_sel == GAIN_0DB) ? 3'h0 :
                          (i_comp_gain_sel == GAIN_12DB) ? 3'(GAIN_12DB_SHIFT) :
                          3'(GAIN_24DB_SHIFT); // R14
  wire aeqf_coef_t wind_a = COEF_W'(i_wind_coef_a); // R18
  wire aeqf_coef_t wind_b = COEF_W'(i_wind_coef_b); // R05
  wire aeqf_coef_t sep_a = COEF_W'(i_separation_coef_a);
  wire aeqf_coef_t sep_b = COEF_W'(i_separation_coef_b);
  wire aeqf_coef_t eq_b = COEF_W'(i_eq_coef_b);

  assign adc_in[0] = i_adc_l;
  assign adc_in[1] = i_adc_r;
  assign dac_in[0] = i_dac_l;
  assign dac_in[1] = i_dac_r;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_front
      aeqf_iir_if wind_if ();
      aeqf_iir_if sep_if ();
      logic signed [DC_ACC_W-1:0] dc_nxt;

      assign src[ch] = on_rec ? adc_in[ch] : dac_in[ch]; // R02 R03
      assign dc_nxt = dc_y_r[ch]
                    + (DC_ACC_W'(src[ch] - dc_x1_r[ch]) <<< DC_FRAC)
                    - (dc_y_r[ch] >>> DC_SHIFT); // R01
      assign dc_out[ch] = aeqf_sat(SAT_IN_W'(dc_y_r[ch] >>> DC_FRAC));

      always_ff @(posedge i_clk)
      begin
        if (i_rst || chain_off)
        begin
          dc_y_r[ch] <= '0; // R20
          dc_x1_r[ch] <= '0;
        end
        else if (i_sample_stb)
        begin
          dc_y_r[ch] <= dc_nxt;
          dc_x1_r[ch] <= src[ch];
        end
      end

      assign wind_if.stb = i_sample_stb;
      assign wind_if.clr = !wind_on; // R20
      assign wind_if.b0 = wind_a; // R07
      assign wind_if.b1 = (i_wind_filter_type_sel == TYPE_LPF) ? wind_a : -wind_a; // R08
      assign wind_if.a1 = wind_b;
      assign wind_if.x = dc_out[ch]; // R16
      assign wind_out[ch] = wind_on ? wind_if.y : dc_out[ch]; // R09

      assign sep_if.stb = i_sample_stb;
      assign sep_if.clr = !sep_on;
      assign sep_if.b0 = sep_a; // R07 R12
      assign sep_if.b1 = (i_separation_filter_type_sel == TYPE_LPF) ? sep_a : -sep_a; // R08
      assign sep_if.a1 = sep_b;
      assign sep_if.x = wind_out[ch];
      assign sep_y[ch] = sep_on ? sep_if.y : '0; // R10

      aeqf_iir1 u_wind (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .f (wind_if.filt)
      );

      aeqf_iir1 u_sep (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .f (sep_if.filt)
      );
    end
  endgenerate

  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_back
      aeqf_iir_if eq_if ();
      // The emphasis branch adds this channel's filtered signal minus the other's.
      assign sep_out[ch] = aeqf_sat(SAT_IN_W'(wind_out[ch]) + SAT_IN_W'(sep_y[ch])
                                    - SAT_IN_W'(sep_y[1-ch])); // R12 R13

      assign eq_if.stb = i_sample_stb;
      assign eq_if.clr = !eq_on;
      assign eq_if.b0 = i_eq_coef_a; // R07
      assign eq_if.b1 = i_eq_coef_c;
      assign eq_if.a1 = eq_b;
      assign eq_if.x = sep_out[ch];
      assign eq_out[ch] = eq_on ? eq_if.y : sep_out[ch]; // R09

      assign gain_full[ch] = SAT_IN_W'(eq_out[ch]) <<< gain_shift; // R14
      assign gain_out[ch] = aeqf_sat(gain_full[ch]);

      aeqf_iir1 u_eq (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .f (eq_if.filt)
      );

      always_ff @(posedge i_clk)
      begin
        if (i_rst)
        begin
          adc_r[ch] <= '0;
          dac_r[ch] <= '0;
        end
        else if (i_sample_stb)
        begin
          adc_r[ch] <= on_rec ? gain_out[ch] : adc_in[ch]; // R02 R03
          dac_r[ch] <= on_play ? gain_out[ch] : dac_in[ch]; // R02 R03
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      valid_r <= 1'b0;
      rec_r <= 1'b0;
      play_r <= 1'b0;
    end
    else
    begin
      valid_r <= i_sample_stb; // R19
      rec_r <= on_rec; // R04
      play_r <= on_play; // R04
    end
  end

  assign o_adc_l = adc_r[0];
  assign o_adc_r = adc_r[1];
  assign o_dac_l = dac_r[0];
  assign o_dac_r = dac_r[1];
  assign o_valid = valid_r;
  assign o_chain_on_rec = rec_r;
  assign o_chain_on_play = play_r;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_rec_sample;
    i_sample_stb && on_rec;
  endsequence

  sequence s_play_sample;
    i_sample_stb && on_play;
  endsequence

  sequence s_power_down;
    chain_off ##1 chain_off;
  endsequence

  a_path_rec_sel: // R04
    assert property (on_rec |=> o_chain_on_rec && !o_chain_on_play)
      else $error("Chain not placed on recording path.");
  a_path_play_sel: // R04
    assert property (on_play |=> o_chain_on_play && !o_chain_on_rec)
      else $error("Chain not placed on playback path.");
  a_dac_bypass_rec: // R02
    assert property (s_rec_sample |=> o_dac_l == $past(i_dac_l) && o_dac_r == $past(i_dac_r))
      else $error("DAC path not bypassed while recording.");
  a_adc_bypass_play: // R03
    assert property (s_play_sample |=> o_adc_l == $past(i_adc_l) && o_adc_r == $past(i_adc_r))
      else $error("ADC path not bypassed during playback.");
  a_wind_through_off: // R09
    assert property (!i_wind_filter_en |-> wind_out[0] == dc_out[0] && wind_out[1] == dc_out[1])
      else $error("Disabled wind stage altered samples.");
  a_eq_through_off: // R09
    assert property (!i_eq_en |-> eq_out[0] == sep_out[0] && eq_out[1] == sep_out[1])
      else $error("Disabled EQ stage altered samples.");
  a_sep_mute_off: // R10
    assert property (!i_separation_filter_en |-> sep_y[0] == '0 && sep_y[1] == '0)
      else $error("Disabled separation stage not muted.");
  a_sep_mono_off: // R13
    assert property (on_rec && i_mono_mix |-> sep_y[0] == '0 && sep_y[1] == '0)
      else $error("Separation emphasis active outside stereo.");
  a_mono_eq_off: // R15
    assert property (on_rec && i_mono_mix |-> eq_out[0] == sep_out[0])
      else $error("EQ active in mono mix.");
  a_gain_twelve_db: // R14
    assert property (i_comp_gain_sel == GAIN_12DB |-> gain_full[0] == SAT_IN_W'(eq_out[0]) * 4)
      else $error("Gain select 01 is not +12 dB.");
  a_gain_24_db: // R14
    assert property (i_comp_gain_sel[1] |-> gain_full[1] == SAT_IN_W'(eq_out[1]) * 16)
      else $error("Gain select 1x is not +24 dB.");
  a_state_clear_off: // R20
    assert property (s_power_down |-> dc_y_r[0] == '0 && dc_x1_r[1] == '0)
      else $error("Filter state kept while powered down.");
  a_valid_per_sample: // R19
    assert property (i_sample_stb |=> o_valid ##1 (o_valid == $past(i_sample_stb)))
      else $error("Output strobe does not follow the sample strobe.");
endmodule

//--- src/aeqf_iir1.sv
// First-order IIR section y = (b0*x + b1*x1 - a1*y1) / 2^13.
`timescale 1ns/1ps
module aeqf_iir1
  import aeqf_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  aeqf_iir_if.filt f
);
  aeqf_sample_t x1_r;
  aeqf_sample_t y1_r;
  logic signed [SAT_IN_W-1:0] acc;
  logic signed [SAT_IN_W-1:0] scaled;

  assign acc = SAT_IN_W'(f.b0 * f.x) + SAT_IN_W'(f.b1 * x1_r) - SAT_IN_W'(f.a1 * y1_r); // R19
  assign scaled = acc >>> COEF_FRAC; // R17
  assign f.y = aeqf_sat(scaled);

  always_ff @(posedge i_clk)
  begin
    if (i_rst || f.clr)
    begin
      x1_r <= '0; // R20
      y1_r <= '0;
    end
    else if (f.stb)
    begin
      x1_r <= f.x;
      y1_r <= f.y;
    end
  end
endmodule

//--- verif/aeqf_src.sv
// Sample source standing in for the converter output and playback input paths.
`timescale 1ns/1ps
module aeqf_src
  import aeqf_pkg::*;
(
  input wire logic i_clk,
  output logic o_stb,
  output aeqf_sample_t o_adc_l,
  output aeqf_sample_t o_adc_r,
  output aeqf_sample_t o_dac_l,
  output aeqf_sample_t o_dac_r
);
  initial
  begin
    o_stb = 1'b0;
    {o_adc_l, o_adc_r, o_dac_l, o_dac_r} = '0;
  end

  // Presents one frame for one clock, then inverts the lines so stale data never looks held.
  task automatic send(input aeqf_sample_t al, input aeqf_sample_t ar,
                      input aeqf_sample_t dl, input aeqf_sample_t dr);
    @(negedge i_clk);
    o_stb = 1'b1;
    {o_adc_l, o_adc_r, o_dac_l, o_dac_r} = {al, ar, dl, dr};
    @(negedge i_clk);
    o_stb = 1'b0;
    {o_adc_l, o_adc_r, o_dac_l, o_dac_r} = ~{al, ar, dl, dr};
  endtask
endmodule

//--- verif/tb.sv
// Self-checking bench for the audio filter chain.
`timescale 1ns/1ps
module tb;
  import aeqf_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic stb, ov, onrec, onplay;
  aeqf_sample_t al, ar, dl, dr, oal, oar, odl, odr;
  logic pl = 1'b0, pr = 1'b0, pd = 1'b0, mix = 1'b0;
  logic wen = 1'b0, wty = 1'b0, sen = 1'b0, sty = 1'b0, een = 1'b0;
  logic signed [WIND_COEF_W-1:0] wa = '0, wb = '0, sa = '0, sb = '0, eb = '0;
  logic signed [COEF_W-1:0] ea = '0, ec = '0;
  logic [1:0] gs = 2'h0;
  int mismatches = 0;
  int check_count = 0;
  int mul[4] = '{1, 4, 16, 16};

  always #4 i_clk = ~i_clk;

  aeqf_src aeqf_src_inst (.i_clk(i_clk), .o_stb(stb), .o_adc_l(al), .o_adc_r(ar),
    .o_dac_l(dl), .o_dac_r(dr));

  aeqf_chain aeqf_chain_inst (.i_clk(i_clk), .i_rst(i_rst), .i_sample_stb(stb),
    .i_adc_l(al), .i_adc_r(ar), .i_dac_l(dl), .i_dac_r(dr),
    .i_left_adc_power_en(pl), .i_right_adc_power_en(pr), .i_dac_power_en(pd),
    .i_mono_mix(mix), .i_wind_filter_en(wen), .i_wind_filter_type_sel(wty),
    .i_wind_coef_a(wa), .i_wind_coef_b(wb), .i_separation_filter_en(sen),
    .i_separation_filter_type_sel(sty), .i_separation_coef_a(sa), .i_separation_coef_b(sb),
    .i_eq_en(een), .i_eq_coef_a(ea), .i_eq_coef_b(eb), .i_eq_coef_c(ec),
    .i_comp_gain_sel(gs), .o_adc_l(oal), .o_adc_r(oar), .o_dac_l(odl), .o_dac_r(odr),
    .o_valid(ov), .o_chain_on_rec(onrec), .o_chain_on_play(onplay));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_s(input string nm, input aeqf_sample_t exp, input aeqf_sample_t got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  task automatic chk_b(input string nm, input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", nm, exp, got);
    end
  endtask

  function automatic aeqf_sample_t lim(input int v);
    if (v > 32767)
      return SAMPLE_MAX;
    if (v < -32768)
      return SAMPLE_MIN;
    return aeqf_sample_t'(v);
  endfunction

  // Clears the chain with all power off, then sends a step of 4096 three times down one path.
  task automatic run3(input logic rec, input int e2, input int e3);
    aeqf_sample_t e[3];
    aeqf_sample_t x;
    aeqf_sample_t y;
    e = '{16'sh0000, lim(e2), lim(e3)};
    x = rec ? 16'sh1000 : 16'sh04D2;
    y = rec ? 16'sh04D2 : 16'sh1000;
    pl = 1'b0;
    pr = 1'b0;
    pd = 1'b0;
    repeat (2) @(negedge i_clk);
    aeqf_src_inst.send(16'sh004D, -16'sh004D, 16'sh0037, -16'sh0037);
    chk_s("adc raw when off", 16'sh004D, oal);
    chk_s("dac raw when off", 16'sh0037, odl);
    chk_b("chain off", 1'b0, onrec | onplay);
    pl = rec;
    pr = rec;
    pd = 1'b1;
    repeat (2) @(negedge i_clk);
    chk_b("chain on rec", rec, onrec);
    chk_b("chain on play", !rec, onplay);
    for (int i = 0; i < 3; i++)
    begin
      aeqf_src_inst.send(x, -x, y, -y);
      chk_b("valid", 1'b1, ov);
      chk_s("chain out", e[i], rec ? oal : odl);
      chk_s("bypass left", 16'sh04D2, rec ? odl : oal);
      chk_s("bypass right", -16'sh04D2, rec ? odr : oar);
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    give_verdict();
  end

  initial
  begin
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk_s("adc out in reset", 16'sh0000, oal);
    chk_b("valid in reset", 1'b0, ov);
    i_rst = 1'b0;
    for (int g = 0; g < 4; g++)
    begin
      gs = 2'(g);
      run3(g[0], 4096 * mul[g], 4095 * mul[g]);
    end
    gs = 2'h0;
    wa = 14'sh1000;
    wen = 1'b1;
    run3(1'b1, 2048, -1);
    run3(1'b0, 2048, -1);
    wen = 1'b0;
    @(negedge i_clk);
    wty = 1'b1;
    wen = 1'b1;
    run3(1'b0, 2048, 4095);
    wen = 1'b0;
    @(negedge i_clk);
    wty = 1'b0;
    wb = 14'sh1000;
    wen = 1'b1;
    run3(1'b1, 2048, -1025);
    wen = 1'b0;
    @(negedge i_clk);
    ea = 16'sh2000;
    ec = 16'shF000;
    eb = 14'sh1000;
    een = 1'b1;
    run3(1'b1, 4096, -1);
    een = 1'b0;
    wen = 1'b1;
    mix = 1'b1;
    run3(1'b1, 2048, -1025);
    mix = 1'b0;
    wen = 1'b0;
    @(negedge i_clk);
    sa = 14'sh1000;
    sen = 1'b1;
    run3(1'b1, 8192, 4094);
    sen = 1'b0;
    @(negedge i_clk);
    sty = 1'b1;
    sen = 1'b1;
    run3(1'b0, 8192, 12286);
    sen = 1'b0;
    give_verdict();
  end
endmodule
